// ### design/sec_err_log_pkg.sv
package sec_err_log_pkg;

    // Extended configuration space offsets
    localparam logic [11:0] ERROR_CAPABILITY_CONTROL_OFS = 12'h138;
    localparam logic [11:0] HEADER_LOG_WORD0_OFS         = 12'h13c;
    localparam logic [11:0] HEADER_LOG_WORD1_OFS         = 12'h140;
    localparam logic [11:0] HEADER_LOG_WORD2_OFS         = 12'h144;
    localparam logic [11:0] HEADER_LOG_WORD3_OFS         = 12'h148;

    // Reset values
    localparam logic [31:0] ERROR_CAPABILITY_CONTROL_RST = 32'h0000_0000;
    localparam logic [31:0] HEADER_LOG_WORD_RST          = 32'h0000_0000;

    // First-error pointer field
    localparam int          POINTER_WIDTH = 5;
    localparam int          POINTER_LSB   = 0;
    localparam int          POINTER_MSB   = 4;
    localparam logic [4:0]  POINTER_RST   = 5'h00;

    // Header log field layout
    localparam int LOG_WIDTH          = 128;
    localparam int WORD_WIDTH         = 32;
    localparam int LOG_WORDS          = 4;
    localparam int ADDR_PHASE2_MSB    = 127;
    localparam int ADDR_PHASE2_LSB    = 96;
    localparam int ADDR_PHASE1_MSB    = 95;
    localparam int ADDR_PHASE1_LSB    = 64;
    localparam int RSVD_LOG_MSB       = 63;
    localparam int RSVD_LOG_LSB       = 44;
    localparam int UPPER_CMD_MSB      = 43;
    localparam int UPPER_CMD_LSB      = 40;
    localparam int LOWER_CMD_MSB      = 39;
    localparam int LOWER_CMD_LSB      = 36;
    localparam int ATTRIBUTE_MSB      = 35;
    localparam int ATTRIBUTE_LSB      = 0;

    // Error class bit positions in the uncorrectable status register
    localparam logic [4:0] CLASS_SYSTEM_ERROR   = 5'h0c;
    localparam logic [4:0] CLASS_PARITY_ERROR   = 5'h0b;
    localparam logic [4:0] CLASS_DISCARD_TIMER  = 5'h0a;
    localparam logic [4:0] CLASS_UNCOR_ADDRESS  = 5'h09;
    localparam logic [4:0] CLASS_UNCOR_DATA     = 5'h07;
    localparam logic [4:0] CLASS_MASTER_ABORT   = 5'h03;
    localparam logic [4:0] CLASS_TARGET_ABORT   = 5'h02;

    localparam int STATUS_WIDTH = 32;

endpackage

// ### design/reset_pin_sync.sv
`timescale 1ns/1ps
module reset_pin_sync
#(
    parameter int WIDTH = 2
)
(
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset,
    // Asynchronous pins and their synchronised copies
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync
);

    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage1_nxt;
    logic [WIDTH-1:0] stage2_nxt;

    if (WIDTH < 1)
    begin : g_bad_width
        $error("reset_pin_sync needs WIDTH of at least 1");
    end

    // Pins are active low, so reset parks both stages at idle high
    always_comb
    begin
        stage1_nxt = reset ? {WIDTH{1'b1}} : pin_in;
        stage2_nxt = reset ? {WIDTH{1'b1}} : stage1_r;
    end

    always_ff @(posedge sys_clk)
    begin
        stage1_r <= stage1_nxt;
        stage2_r <= stage2_nxt;
    end

    assign pin_sync = stage2_r;

endmodule // reset_pin_sync

// ### design/header_log_capture.sv
`timescale 1ns/1ps
module header_log_capture
    import sec_err_log_pkg::*;
(
    // Clock and clear
    input  wire logic                  sys_clk,
    input  wire logic                  clear,
    // Capture request and bus cycle fields
    input  wire logic                  capture,
    input  wire logic [31:0]           addr_phase1,
    input  wire logic [31:0]           addr_phase2,
    input  wire logic [3:0]            cmd_phase1,
    input  wire logic [3:0]            cmd_phase2,
    input  wire logic                  dual_address,
    // Assembled log
    output logic      [LOG_WIDTH-1:0]  header_log
);

    logic [31:0] addr_lo_r;
    logic [31:0] addr_hi_r;
    logic [3:0]  cmd_lo_r;
    logic [3:0]  cmd_hi_r;
    logic [31:0] addr_lo_nxt;
    logic [31:0] addr_hi_nxt;
    logic [3:0]  cmd_lo_nxt;
    logic [3:0]  cmd_hi_nxt;

    always_comb
    begin
        addr_lo_nxt = addr_lo_r;
        addr_hi_nxt = addr_hi_r;
        cmd_lo_nxt  = cmd_lo_r;
        cmd_hi_nxt  = cmd_hi_r;
        if (clear)
        begin
            addr_lo_nxt = '0;
            addr_hi_nxt = '0;
            cmd_lo_nxt  = '0;
            cmd_hi_nxt  = '0;
        end
        else if (capture)
        begin
            // Each new error replaces the whole earlier record
            addr_lo_nxt = addr_phase1;
            addr_hi_nxt = dual_address ? addr_phase2 : 32'h0000_0000;
            cmd_lo_nxt  = cmd_phase1;
            cmd_hi_nxt  = dual_address ? cmd_phase2 : 4'h0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        addr_lo_r <= addr_lo_nxt;
        addr_hi_r <= addr_hi_nxt;
        cmd_lo_r  <= cmd_lo_nxt;
        cmd_hi_r  <= cmd_hi_nxt;
    end

    always_comb
    begin
        header_log = '0;
        header_log[ADDR_PHASE2_MSB:ADDR_PHASE2_LSB] = addr_hi_r;
        header_log[ADDR_PHASE1_MSB:ADDR_PHASE1_LSB] = addr_lo_r;
        header_log[UPPER_CMD_MSB:UPPER_CMD_LSB]     = cmd_hi_r;
        header_log[LOWER_CMD_MSB:LOWER_CMD_LSB]     = cmd_lo_r;
    end

endmodule // header_log_capture

// ### design/secondary_error_log.sv
`timescale 1ns/1ps
module secondary_error_log
    import sec_err_log_pkg::*;
(
    // Clock and power-on reset
    input  wire logic                    sys_clk,
    input  wire logic                    reset,
    // Reset pins, active low, asynchronous
    input  wire logic                    fundamental_reset_pin_n,
    input  wire logic                    global_reset_pin_n,
    // Configuration access port
    input  wire logic                    cfg_rd_en,
    input  wire logic                    cfg_wr_en,
    input  wire logic [11:0]             cfg_addr,
    input  wire logic [31:0]             cfg_wdata,
    output logic      [31:0]             cfg_rdata,
    output logic                         cfg_rd_valid,
    // Error detection from the status register logic
    input  wire logic                    err_strobe,
    input  wire logic [4:0]              err_bit_index,
    input  wire logic [STATUS_WIDTH-1:0] err_status,
    // Bus cycle that caused the error
    input  wire logic [31:0]             cycle_addr_phase1,
    input  wire logic [31:0]             cycle_addr_phase2,
    input  wire logic [3:0]              cycle_cmd_phase1,
    input  wire logic [3:0]              cycle_cmd_phase2,
    input  wire logic                    cycle_dual_address,
    // Current first-error pointer
    output logic      [POINTER_WIDTH-1:0] first_error_pointer
);

    logic [1:0]                 pins_sync;
    logic                       log_clear;
    logic                       known_class;
    logic [LOG_WIDTH-1:0]       header_log;
    logic [POINTER_WIDTH-1:0]   pointer_r;
    logic [POINTER_WIDTH-1:0]   pointer_nxt;
    logic                       pointer_held_r;
    logic                       pointer_held_nxt;
    logic [31:0]                rdata_r;
    logic [31:0]                rdata_nxt;
    logic                       rd_valid_r;
    logic                       rd_valid_nxt;
    logic [31:0]                cap_word;

    reset_pin_sync #(
        .WIDTH    (2)
    ) u_pin_sync (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .pin_in   ({fundamental_reset_pin_n, global_reset_pin_n}),
        .pin_sync (pins_sync)
    );

    // Any of the three resets clears the log state
    assign log_clear = reset | ~pins_sync[1] | ~pins_sync[0];

    always_comb
    begin
        case (err_bit_index)
            CLASS_SYSTEM_ERROR,
            CLASS_PARITY_ERROR,
            CLASS_DISCARD_TIMER,
            CLASS_UNCOR_ADDRESS,
            CLASS_UNCOR_DATA,
            CLASS_MASTER_ABORT,
            CLASS_TARGET_ABORT: known_class = 1'b1;
            default:            known_class = 1'b0;
        endcase
    end

    header_log_capture u_capture (
        .sys_clk      (sys_clk),
        .clear        (log_clear),
        .capture      (err_strobe),
        .addr_phase1  (cycle_addr_phase1),
        .addr_phase2  (cycle_addr_phase2),
        .cmd_phase1   (cycle_cmd_phase1),
        .cmd_phase2   (cycle_cmd_phase2),
        .dual_address (cycle_dual_address),
        .header_log   (header_log)
    );

    // First-error pointer
    always_comb
    begin
        pointer_nxt      = pointer_r;
        pointer_held_nxt = pointer_held_r;
        if (log_clear)
        begin
            pointer_nxt      = POINTER_RST;
            pointer_held_nxt = 1'b0;
        end
        else
        begin
            // Held stays set until a reset; the named status bit and known_class
            // decide whether a later error may take the pointer over.
            // A new error while the old one is gone is a new first error
            if (err_strobe && known_class &&
                (!pointer_held_r || !err_status[pointer_r]))
            begin
                pointer_nxt      = err_bit_index;
                pointer_held_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        pointer_r      <= pointer_nxt;
        pointer_held_r <= pointer_held_nxt;
    end

    // Read path; writes are decoded nowhere and leave all state alone
    always_comb
    begin
        cap_word = ERROR_CAPABILITY_CONTROL_RST;
        cap_word[POINTER_MSB:POINTER_LSB] = pointer_r;
    end

    always_comb
    begin
        rdata_nxt    = rdata_r;
        rd_valid_nxt = 1'b0;
        if (reset)
        begin
            rdata_nxt = HEADER_LOG_WORD_RST;
        end
        else if (cfg_rd_en)
        begin
            rd_valid_nxt = 1'b1;
            case (cfg_addr)
                ERROR_CAPABILITY_CONTROL_OFS: rdata_nxt = cap_word;
                HEADER_LOG_WORD0_OFS: rdata_nxt = header_log[31:0];
                HEADER_LOG_WORD1_OFS: rdata_nxt = header_log[63:32];
                HEADER_LOG_WORD2_OFS: rdata_nxt = header_log[95:64];
                HEADER_LOG_WORD3_OFS: rdata_nxt = header_log[127:96];
                default:              rdata_nxt = 32'h0000_0000;
            endcase
        end
        else if (cfg_wr_en)
        begin
            rdata_nxt = rdata_r;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        rdata_r    <= rdata_nxt;
        rd_valid_r <= rd_valid_nxt;
    end

    assign cfg_rdata           = rdata_r;
    assign cfg_rd_valid        = rd_valid_r;
    assign first_error_pointer = pointer_r;

endmodule // secondary_error_log

// ### tb/sec_err_log_sva.sv
`timescale 1ns/1ps
module sec_err_log_sva
    import sec_err_log_pkg::*;
(
    // Clock and reset
    input wire logic                     sys_clk,
    input wire logic                     reset,
    // Configuration access
    input wire logic                     cfg_rd_en,
    input wire logic [11:0]              cfg_addr,
    input wire logic [31:0]              cfg_rdata,
    input wire logic                     cfg_rd_valid,
    // Error detection
    input wire logic                     err_strobe,
    input wire logic [4:0]               err_bit_index,
    input wire logic [STATUS_WIDTH-1:0]  err_status,
    input wire logic [POINTER_WIDTH-1:0] first_error_pointer
);
    wire logic idx_ok = err_bit_index inside {5'h0c, 5'h0b, 5'h0a, 5'h09,
                                              5'h07, 5'h03, 5'h02};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence s_rd(logic [11:0] a);
        cfg_rd_en && cfg_addr == a;
    endsequence
    a_rd_answer:
        assert property (cfg_rd_en |=> cfg_rd_valid) else $error("no answer");
    a_no_answer:
        assert property (!cfg_rd_en |=> !cfg_rd_valid) else $error("stray valid");
    a_rd_hold:
        assert property (!cfg_rd_en |=> $stable(cfg_rdata))
            else $error("read data moved");
    a_cap_read:
        assert property (s_rd(12'h138) |=>
            cfg_rdata == {27'h0, $past(first_error_pointer)})
            else $error("pointer read wrong");
    a_attr_zero:
        assert property (s_rd(12'h13c) |=> cfg_rdata == 32'h0)
            else $error("attribute bits set");
    a_rsvd_zero:
        assert property (s_rd(12'h140) |=>
            cfg_rdata[31:12] == 20'h0 && cfg_rdata[3:0] == 4'h0)
            else $error("reserved bits set");
    a_ptr_load:
        assert property (err_strobe && idx_ok && !err_status[first_error_pointer]
            |=> first_error_pointer == $past(err_bit_index))
            else $error("pointer not loaded");
    a_ptr_hold:
        assert property (err_strobe && (!idx_ok || err_status[first_error_pointer])
            |=> $stable(first_error_pointer)) else $error("pointer overwritten");
endmodule // sec_err_log_sva

bind secondary_error_log sec_err_log_sva i_sva (.sys_clk, .reset, .cfg_rd_en,
    .cfg_addr, .cfg_rdata, .cfg_rd_valid, .err_strobe, .err_bit_index,
    .err_status, .first_error_pointer);

// ### tb/pci_agent_model.sv
`timescale 1ns/1ps
module pci_agent_model
(
    // Clock
    input  wire logic  sys_clk,
    // Errored bus cycle
    output logic       err_strobe,
    output logic [4:0] err_bit_index,
    output logic [31:0] cyc_addr1,
    output logic [31:0] cyc_addr2,
    output logic [3:0] cyc_cmd1,
    output logic [3:0] cyc_cmd2,
    output logic       cyc_dual
);
    initial {err_strobe, err_bit_index, cyc_addr1, cyc_addr2} = '0;
    initial {cyc_cmd1, cyc_cmd2, cyc_dual} = '0;
    task send(input logic [4:0] i, input logic [31:0] a1, a2,
              input logic [3:0] c1, c2, input logic d);
        @(negedge sys_clk);
        {err_strobe, err_bit_index, cyc_addr1, cyc_addr2} = {1'b1, i, a1, a2};
        {cyc_cmd1, cyc_cmd2, cyc_dual} = {c1, c2, d};
        @(negedge sys_clk);
        err_strobe = 1'b0;
        // Released bus no longer shows the logged cycle
        {err_bit_index, cyc_addr1, cyc_addr2} = ~{i, a1, a2};
        {cyc_cmd1, cyc_cmd2, cyc_dual} = ~{c1, c2, d};
    endtask
endmodule // pci_agent_model

// ### tb/secondary_error_log_tb_top.sv
`timescale 1ns/1ps
module secondary_error_log_tb_top
    import sec_err_log_pkg::*;
;
    logic sys_clk, reset, fr_n, gr_n, rd_en, wr_en, rd_valid, strobe, dual;
    logic [11:0] addr;
    logic [31:0] wdata, rdata, a1, a2, status;
    logic [4:0]  idx, ptr;
    logic [3:0]  c1, c2;
    logic [4:0]  cls [7] = '{5'h0c, 5'h0b, 5'h0a, 5'h09, 5'h07, 5'h03, 5'h02};
    int          n_fail, comparisons;

    secondary_error_log i_dut (.sys_clk(sys_clk), .reset(reset),
        .fundamental_reset_pin_n(fr_n), .global_reset_pin_n(gr_n),
        .cfg_rd_en(rd_en), .cfg_wr_en(wr_en), .cfg_addr(addr),
        .cfg_wdata(wdata), .cfg_rdata(rdata), .cfg_rd_valid(rd_valid),
        .err_strobe(strobe), .err_bit_index(idx), .err_status(status),
        .cycle_addr_phase1(a1), .cycle_addr_phase2(a2), .cycle_cmd_phase1(c1),
        .cycle_cmd_phase2(c2), .cycle_dual_address(dual),
        .first_error_pointer(ptr));
    pci_agent_model i_agent (.sys_clk(sys_clk), .err_strobe(strobe),
        .err_bit_index(idx), .cyc_addr1(a1), .cyc_addr2(a2), .cyc_cmd1(c1),
        .cyc_cmd2(c2), .cyc_dual(dual));

    task stop_test;
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task rc(input logic [11:0] a, input logic [31:0] exp);
        @(negedge sys_clk);
        {rd_en, addr} = {1'b1, a};
        @(negedge sys_clk);
        rd_en = 1'b0;
        chk({31'h0, rd_valid}, 32'h1);
        chk(rdata, exp);
    endtask
    task wr(input logic [11:0] a);
        @(negedge sys_clk);
        {wr_en, addr, wdata} = {1'b1, a, 32'hffff_ffff};
        @(negedge sys_clk);
        wr_en = 1'b0;
    endtask
    task zeros;
        for (int k = 0; k < 6; k++)
            rc(12'h138 + 12'(4 * k), 32'h0);
    endtask
    task err(input logic [4:0] i, input logic [31:0] x1, x2,
             input logic [3:0] y1, y2, input logic d, input logic [4:0] p);
        i_agent.send(i, x1, x2, y1, y2, d);
        wr(12'h148);
        rc(12'h13c, 32'h0);
        rc(12'h140, {20'h0, d ? y2 : 4'h0, y1, 4'h0});
        rc(12'h144, x1);
        rc(12'h148, d ? x2 : 32'h0);
        rc(12'h138, {27'h0, p});
        chk({27'h0, ptr}, {27'h0, p});
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial
    begin
        #500000;
        n_fail++;
        stop_test;
    end
    initial
    begin
        {reset, fr_n, gr_n, rd_en, wr_en, addr, wdata} = {3'b111, 46'h0};
        status = 32'h0;
        repeat (10) @(negedge sys_clk);
        reset = 1'b0;
        repeat (2) @(negedge sys_clk);
        zeros();
        $display("test reset values done");
        for (int k = 0; k < 5; k++)
            wr(12'h138 + 12'(4 * k));
        zeros();
        $display("test write refusal done");
        for (int k = 0; k < 7; k++)
            err(cls[k], 32'hc0de_0000 | k, 32'h5a5a_0000 | k, cls[k][3:0],
                ~cls[k][3:0], k[0], cls[k]);
        $display("test error classes done");
        status = 32'h4;
        err(5'h0c, 32'h1234_5678, 32'h9abc_def0, 4'h6, 4'hd, 1'b1, 5'h02);
        status = 32'h0;
        err(5'h05, 32'h0f0f_0f0f, 32'hf0f0_f0f0, 4'h3, 4'h9, 1'b0, 5'h02);
        err(5'h09, 32'h8000_0001, 32'h7fff_fffe, 4'hb, 4'h4, 1'b1, 5'h09);
        $display("test pointer hold done");
        for (int k = 0; k < 2; k++)
        begin
            err(5'h03, 32'haaaa_5555, 32'h5555_aaaa, 4'hf, 4'he, 1'b1, 5'h03);
            @(negedge sys_clk);
            {fr_n, gr_n} = k ? 2'b10 : 2'b01;
            repeat (3) @(negedge sys_clk);
            {fr_n, gr_n} = 2'b11;
            repeat (3) @(negedge sys_clk);
            zeros();
        end
        $display("test pin resets done");
        stop_test;
    end
endmodule // secondary_error_log_tb_top
